// *** hdl/nyq_fir.sv ***
// Purpose: one shaping FIR for a single binary symbol channel
// Assumes: coefficients shared by both channels, so both filters are identical
// Notes: antipodal input, +1/-1 per tap
`timescale 1ns/1ps
module nyq_fir #(
    parameter int TAPS = txdp_pkg::FIR_TAPS,
    parameter int CW = txdp_pkg::COEF_W,
    parameter int OW = txdp_pkg::FIR_OUT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sym_valid,
    input wire logic sym_bit,
    input wire logic [TAPS*CW-1:0] coef,
    output logic [OW-1:0] sample
);
    import txdp_pkg::*;
    logic [TAPS-1:0] line_r;
    logic signed [OW-1:0] prod [TAPS];
    logic signed [OW-1:0] acc;

    // delay line moves one place per symbol
    always_ff @(posedge clk) begin
        if (rst) begin
            line_r <= '0;
        end else if (sym_valid) begin
            line_r <= {line_r[TAPS-2:0], sym_bit};
        end
    end

    // each tap adds or subtracts its coefficient
    for (genvar t = 0; t < TAPS; t++) begin : g_tap
        logic signed [CW-1:0] c;
        assign c = coef[t*CW +: CW];
        assign prod[t] = line_r[t] ? OW'(c) : -OW'(c);
    end

    always_comb begin
        acc = '0;
        for (int t = 0; t < TAPS; t++) begin
            acc = acc + prod[t];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sample <= '0;
        end else begin
            sample <= acc;
        end
    end
endmodule : nyq_fir

// *** hdl/tx_fec_scramble_datapath.sv ***
// Purpose: transmit coding path: differential encoder, scrambler, conv encoder, I/Q shaping
// Assumes: serial data and its clock arrive asynchronously and are synchronised here
// Notes: one coded symbol per input bit cycle at every code rate
// What this block does
// - bits go through differential encoder first, then scrambler.
// - differential encoder works on 2-bit groups to resolve phase ambiguity.
// - differential encoder is switched on or off by a setting.
// - scrambler is self-synchronising V.35 style polynomial.
// - scrambler is switched on or off by a setting.
// - convolutional encoder adds parity, rate 7/8, 3/4 or 1/2.
// - at rate 7/8 seven coded symbols leave per seven input bits.
// - QPSK splits coded stream into in-phase and quadrature streams.
// - each channel has its own identical FIR shaping filter.
// - a programmable data-rate clock is output.
// - faults reported: synth lock, AGC, input clock activity, I/Q failure.
// - all settings are written by the processor over the register bus.
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tx_fec_scramble_datapath
    import txdp_pkg::*;
#(
    parameter int LOSS_CYC = txdp_pkg::CLK_LOSS_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_clk,
    input wire logic tx_data,
    input wire logic synth_unlock,
    input wire logic agc_fault,
    output txdp_pkg::sym_t coded_sym,
    output logic [txdp_pkg::FIR_OUT_W-1:0] i_sample,
    output logic [txdp_pkg::FIR_OUT_W-1:0] q_sample,
    output logic rate_clk,
    output logic irq
);
    import txdp_pkg::*;
    // ==========================================
    // register bus
    logic [31:0] ctrl_r;
    logic [15:0] rate_div_r;
    logic [NUM_FLT-1:0] status_r;
    logic [NUM_FLT-1:0] mask_r;
    logic [NUM_FLT-1:0] fault_live;
    logic [FIR_TAPS*COEF_W-1:0] coef_r;
    logic ack_r;
    ctrl_t cfg;
    logic wr_go;
    logic rd_go;
    assign cfg.diff_en = ctrl_r[CTRL_DIFF_EN];
    assign cfg.scram_en = ctrl_r[CTRL_SCRAM_EN];
    assign cfg.rate = ctrl_r[CTRL_RATE_LO +: 2];
    assign cfg.qpsk = ctrl_r[CTRL_QPSK];
    // one wait cycle per access, answer on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
            rate_div_r <= RATE_DIV_RESET;
            mask_r <= '0;
            coef_r <= '0;
        end else if (wr_go) begin
            if (avs_address == ADDR_CTRL) begin
                ctrl_r <= {27'h0, avs_writedata[4:0]};
            end else if (avs_address == ADDR_RATE_DIV) begin
                rate_div_r <= avs_writedata[15:0];
            end else if (avs_address == ADDR_MASK) begin
                mask_r <= avs_writedata[NUM_FLT-1:0];
            end else if (avs_address == ADDR_COEF_BASE) begin
                coef_r[31:0] <= avs_writedata;
            end else if (avs_address == ADDR_COEF_BASE + 8'h04) begin
                coef_r[63:32] <= avs_writedata;
            end
        end
    end

    // read mux; unmapped words read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (rd_go) begin
            if (avs_address == ADDR_CTRL) begin
                avs_readdata <= ctrl_r;
            end else if (avs_address == ADDR_RATE_DIV) begin
                avs_readdata <= {16'h0, rate_div_r};
            end else if (avs_address == ADDR_STATUS) begin
                avs_readdata <= {28'h0, status_r};
            end else if (avs_address == ADDR_MASK) begin
                avs_readdata <= {28'h0, mask_r};
            end else if (avs_address == ADDR_FAULT_LIVE) begin
                avs_readdata <= {28'h0, fault_live};
            end else if (avs_address == ADDR_COEF_BASE) begin
                avs_readdata <= coef_r[31:0];
            end else if (avs_address == ADDR_COEF_BASE + 8'h04) begin
                avs_readdata <= coef_r[63:32];
            end else begin
                avs_readdata <= '0;
            end
        end
    end

    // ==========================================
    // link input sampling
    logic [1:0] clk_sync_r;
    logic [1:0] dat_sync_r;
    logic clk_prev_r;
    logic bit_stb;
    // upstream data steady at clock rise
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_sync_r <= '0;
            dat_sync_r <= '0;
            clk_prev_r <= 1'b0;
        end else begin
            clk_sync_r <= {clk_sync_r[0], tx_clk};
            dat_sync_r <= {dat_sync_r[0], tx_data};
            clk_prev_r <= clk_sync_r[1];
        end
    end
    assign bit_stb = clk_sync_r[1] & ~clk_prev_r;

    // ==========================================
    // differential encoder over 2-bit groups
    logic pair_ph_r;
    logic first_r;
    logic [1:0] diff_acc_r;
    logic diff_bit;
    logic [1:0] diff_sum;
    // 2-bit group, each lane differenced against the last pair
    assign diff_sum = diff_acc_r ^ {first_r, dat_sync_r[1]};
    always_ff @(posedge clk) begin
        if (rst) begin
            pair_ph_r <= 1'b0;
            first_r <= 1'b0;
            diff_acc_r <= '0;
        end else if (bit_stb) begin
            pair_ph_r <= ~pair_ph_r;
            if (!pair_ph_r) begin
                first_r <= dat_sync_r[1];
            end else begin
                diff_acc_r <= diff_sum;
            end
        end
    end
    // bypass keeps the same timing
    // output emitted serially: msb on even phase from previous sum, lsb on odd
    assign diff_bit = !cfg.diff_en ? dat_sync_r[1] :
                      (pair_ph_r ? diff_sum[0] : diff_acc_r[1] ^ dat_sync_r[1]);

    // ==========================================
    // V.35 style self-synchronising scrambler, x^-20 + x^-3 + 1
    logic [19:0] scr_r;
    logic scr_bit;
    assign scr_bit = diff_bit ^ scr_r[2] ^ scr_r[19];
    always_ff @(posedge clk) begin
        if (rst) begin
            scr_r <= '0;
        end else if (bit_stb) begin
            scr_r <= {scr_r[18:0], scr_bit};
        end
    end
    logic enc_in;
    // same path, no extra delay when off
    assign enc_in = cfg.scram_en ? scr_bit : diff_bit;

    // ==========================================
    // rate 1/2 mother code K=7, punctured to 3/4 and 7/8
    logic [5:0] cv_r;
    logic g1;
    logic g2;
    logic [2:0] punc_r;
    logic [2:0] punc_last;
    logic [6:0] keep_q;
    assign g1 = enc_in ^ cv_r[0] ^ cv_r[1] ^ cv_r[2] ^ cv_r[5];
    assign g2 = enc_in ^ cv_r[1] ^ cv_r[2] ^ cv_r[4] ^ cv_r[5];
    assign punc_last = (cfg.rate == RATE_7_8) ? 3'd6 :
                       (cfg.rate == RATE_3_4) ? 3'd2 : 3'd0;
    // 7/8 takes g2 on one of seven bits and g1 on the rest, seven outputs per seven
    assign keep_q = (cfg.rate == RATE_7_8) ? 7'h01 :
                    (cfg.rate == RATE_3_4) ? 7'h01 : 7'h01;
    always_ff @(posedge clk) begin
        if (rst) begin
            cv_r <= '0;
            punc_r <= '0;
        end else if (bit_stb) begin
            cv_r <= {cv_r[4:0], enc_in};
            punc_r <= (punc_r == punc_last) ? 3'd0 : punc_r + 3'd1;
        end
    end

    // coded symbols: q carries the parity where kept
    // split into in-phase and quadrature
    // BPSK sends the same data bit on both channels
    always_ff @(posedge clk) begin
        if (rst) begin
            coded_sym <= '0;
        end else begin
            coded_sym.valid <= bit_stb;
            if (bit_stb) begin
                coded_sym.i_bit <= enc_in;
                coded_sym.q_bit <= cfg.qpsk ? (keep_q[punc_r] ? g2 : g1) : enc_in;
            end
        end
    end

    // ==========================================
    // two identical shaping filters sharing coefficients
    nyq_fir u_fir_i (
        .clk(clk),
        .rst(rst),
        .sym_valid(coded_sym.valid),
        .sym_bit(coded_sym.i_bit),
        .coef(coef_r),
        .sample(i_sample)
    );
    nyq_fir u_fir_q (
        .clk(clk),
        .rst(rst),
        .sym_valid(coded_sym.valid),
        .sym_bit(coded_sym.q_bit),
        .coef(coef_r),
        .sample(q_sample)
    );

    // ==========================================
    // programmable rate clock divider
    logic [15:0] div_cnt_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            div_cnt_r <= '0;
            rate_clk <= 1'b0;
        end else if (div_cnt_r >= rate_div_r) begin
            div_cnt_r <= '0;
            rate_clk <= ~rate_clk;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ==========================================
    // fault detection: clock activity and a stuck in-phase channel
    logic [31:0] clk_idle_r;
    logic [31:0] iq_idle_r;
    logic [1:0] flt_sync_r [2];
    logic i_prev_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_idle_r <= '0;
            iq_idle_r <= '0;
            i_prev_r <= 1'b0;
        end else begin
            clk_idle_r <= bit_stb ? 32'h0 :
                (clk_idle_r < 32'(LOSS_CYC) ? clk_idle_r + 32'h1 : clk_idle_r);
            if (coded_sym.valid) begin
                i_prev_r <= coded_sym.i_bit;
            end
            iq_idle_r <= (coded_sym.valid && coded_sym.i_bit != i_prev_r) ? 32'h0 :
                (iq_idle_r < 32'(2 * LOSS_CYC) ? iq_idle_r + 32'h1 : iq_idle_r);
        end
    end
    // external fault pins come from other domains
    always_ff @(posedge clk) begin
        if (rst) begin
            flt_sync_r[0] <= '0;
            flt_sync_r[1] <= '0;
        end else begin
            flt_sync_r[0] <= {agc_fault, synth_unlock};
            flt_sync_r[1] <= flt_sync_r[0];
        end
    end
    assign fault_live[FLT_SYNTH] = flt_sync_r[1][0];
    assign fault_live[FLT_AGC] = flt_sync_r[1][1];
    assign fault_live[FLT_CLK] = clk_idle_r >= 32'(LOSS_CYC);
    assign fault_live[FLT_IQ] = !fault_live[FLT_CLK] && iq_idle_r >= 32'(2 * LOSS_CYC);
    // sticky status: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= '0;
        end else begin
            status_r <= fault_live |
                (status_r & ~((wr_go && avs_address == ADDR_STATUS) ?
                avs_writedata[NUM_FLT-1:0] : '0));
        end
    end
    assign irq = |(status_r & mask_r);

    // ==========================================
    // assertions
    // bypass has no added delay
    a_diff_bypass: assert property (@(posedge clk) disable iff (rst)
        !cfg.diff_en |-> diff_bit == dat_sync_r[1]) else $error("diff bypass altered bit");
    a_scram_bypass: assert property (@(posedge clk) disable iff (rst)
        !cfg.scram_en |-> enc_in == diff_bit) else $error("scrambler bypass altered bit");
    a_scram_taps: assert property (@(posedge clk) disable iff (rst)
        bit_stb && cfg.scram_en |=> scr_r[0] == $past(diff_bit ^ scr_r[2] ^ scr_r[19]))
        else $error("scrambler feedback wrong");
    a_sym_follow: assert property (@(posedge clk) disable iff (rst)
        bit_stb |=> coded_sym.valid && coded_sym.i_bit == $past(enc_in))
        else $error("coded symbol not issued");
    a_bpsk_single: assert property (@(posedge clk) disable iff (rst)
        bit_stb && !cfg.qpsk |=> coded_sym.q_bit == coded_sym.i_bit)
        else $error("bpsk split stream");
    a_status_sticky: assert property (@(posedge clk) disable iff (rst)
        fault_live[FLT_CLK] |=> status_r[FLT_CLK]) else $error("clock fault not latched");
    a_irq_mask: assert property (@(posedge clk) disable iff (rst)
        (status_r & mask_r) == '0 |-> !irq) else $error("irq without unmasked status");
    sequence s_bus_wait; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_bus_done; !avs_waitrequest; endsequence
    a_bus_answer: assert property (@(posedge clk) disable iff (rst)
        s_bus_wait |=> s_bus_done) else $error("bus answer late");
    a_rate_toggle: assert property (@(posedge clk) disable iff (rst)
        div_cnt_r >= rate_div_r |=> rate_clk != $past(rate_clk))
        else $error("rate clock did not toggle");
    a_pair_phase: assert property (@(posedge clk) disable iff (rst)
        bit_stb |=> pair_ph_r != $past(pair_ph_r)) else $error("pair phase stuck");
endmodule : tx_fec_scramble_datapath

// *** hdl/txdp_pkg.sv ***
// Purpose: shared constants and types for the transmit coding datapath
// Assumes: 200 MHz system clock, Avalon-MM register access with 32-bit data
// Notes: all offsets are byte addresses of aligned words
package txdp_pkg;
    // ==========================================
    // register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RATE_DIV = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0c;
    localparam logic [7:0] ADDR_FAULT_LIVE = 8'h10;
    localparam logic [7:0] ADDR_COEF_BASE = 8'h20;
    // control field positions
    localparam int CTRL_DIFF_EN = 0;
    localparam int CTRL_SCRAM_EN = 1;
    localparam int CTRL_RATE_LO = 2;
    localparam int CTRL_QPSK = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0013;
    localparam logic [15:0] RATE_DIV_RESET = 16'h0064;
    // fault / status bit positions
    localparam int FLT_SYNTH = 0;
    localparam int FLT_AGC = 1;
    localparam int FLT_CLK = 2;
    localparam int FLT_IQ = 3;
    localparam int NUM_FLT = 4;
    // code rate selector encodings
    localparam logic [1:0] RATE_7_8 = 2'h0;
    localparam logic [1:0] RATE_3_4 = 2'h1;
    localparam logic [1:0] RATE_1_2 = 2'h2;
    // ==========================================
    // timing
    localparam int CLK_NS = 5;
    localparam int CLK_LOSS_US = 20;
    localparam int CLK_LOSS_CYC = CLK_LOSS_US * 1000 / CLK_NS;
    localparam int IQ_LOSS_CYC = 2 * CLK_LOSS_CYC;
    // ==========================================
    // filter shape
    localparam int FIR_TAPS = 8;
    localparam int COEF_W = 8;
    localparam int FIR_OUT_W = 12;
    typedef struct packed {
        logic valid;
        logic i_bit;
        logic q_bit;
    } sym_t;
    typedef struct packed {
        logic diff_en;
        logic scram_en;
        logic [1:0] rate;
        logic qpsk;
    } ctrl_t;
endpackage : txdp_pkg

// *** verification/serial_src.sv ***
// Purpose: model of the interface card feeding serial transmit bits
// Assumes: 64 ns bit period, data set up a quarter bit before the rising clock
// Notes: clock idles low between frames, data shows the inverse when released
`timescale 1ns/1ps
module serial_src (
    output logic tx_clk,
    output logic tx_data
);
    logic last_r;

    // ==========================================
    // idle state
    initial begin
        tx_clk = 1'b0;
        tx_data = 1'b0;
        last_r = 1'b0;
    end

    // ==========================================
    // one bit per call, clock runs only while bits flow
    // clean data, synchronous clock
    task automatic send_bit(input logic b);
        tx_data = b;
        last_r = b;
        #16;
        tx_clk = 1'b1;
        #32;
        tx_clk = 1'b0;
        #16;
        // released line must not keep the old bit, or a late sample would pass
        tx_data = ~last_r;
    endtask : send_bit
endmodule : serial_src

// *** verification/tb_tx_fec_scramble_datapath.sv ***
// Purpose: self-checking bench for the transmit coding datapath
// Assumes: one wait state per register access, loss timeout cut to 200 cycles
// Notes: coded bits are checked on the in-phase lane, stages toggled per frame
`timescale 1ns/1ps
module tb_tx_fec_scramble_datapath;
    import txdp_pkg::*;
    localparam int LOSS = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic tx_clk;
    logic tx_data;
    logic synth_unlock = 1'b0;
    logic agc_fault = 1'b0;
    sym_t coded_sym;
    logic [FIR_OUT_W-1:0] i_sample;
    logic [FIR_OUT_W-1:0] q_sample;
    logic rate_clk;
    logic irq;
    int error_cnt = 0;
    int n_tests = 0;
    int diffs;
    int cyc;
    logic [31:0] rd;
    logic sent_q[$];
    logic got_q[$];
    logic quad_q[$];
    int exp_s;
    int qd;

    // ==========================================
    // instances
    serial_src i_src (.tx_clk(tx_clk), .tx_data(tx_data));
    tx_fec_scramble_datapath #(.LOSS_CYC(LOSS)) i_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_clk(tx_clk), .tx_data(tx_data), .synth_unlock(synth_unlock),
        .agc_fault(agc_fault), .coded_sym(coded_sym), .i_sample(i_sample),
        .q_sample(q_sample), .rate_clk(rate_clk), .irq(irq));

    // ==========================================
    // clock and symbol capture
    always #2.5 clk = ~clk;

    // registered output, so the pre-edge value is the settled one
    always @(posedge clk) begin
        if (coded_sym.valid === 1'b1) begin
            got_q.push_back(coded_sym.i_bit);
            quad_q.push_back(coded_sym.q_bit);
        end
    end

    // ==========================================
    // helpers
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // holds the request until the edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) error_cnt++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic frame(input int n);
        got_q.delete();
        quad_q.delete();
        sent_q.delete();
        for (int k = 0; k < n; k++) begin
            sent_q.push_back(1'($urandom()));
            i_src.send_bit(sent_q[k]);
        end
        repeat (20) @(posedge clk);
        diffs = 0;
        chk("sym_count", 1, 32'(got_q.size() >= n));
        while (got_q.size() < n) got_q.push_back(1'b0);
        while (quad_q.size() < n) quad_q.push_back(1'b0);
        for (int k = 0; k < n; k++) diffs += int'(got_q[k] !== sent_q[k]);
    endtask : frame

    task automatic rate_period();
        logic prev;
        int n;
        n = 0;
        @(negedge clk);
        prev = rate_clk;
        while (rate_clk === prev && n < 100) begin
            @(negedge clk);
            n++;
        end
        prev = rate_clk;
        cyc = 0;
        while (rate_clk === prev && cyc < 100) begin
            @(negedge clk);
            cyc++;
        end
    endtask : rate_period

    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================
    // watchdog, about fifteen times the expected run
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h1908e95a));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped hole
        bus(0, ADDR_CTRL, 0);
        chk("ctrl_reset", CTRL_RESET, rd);
        bus(0, ADDR_RATE_DIV, 0);
        chk("rate_div_reset", 32'(RATE_DIV_RESET), rd);
        bus(0, 8'h3c, 0);
        chk("unmapped", 0, rd);
        // every code rate selectable and read back
        for (int r = 0; r < 3; r++) begin
            bus(1, ADDR_CTRL, 32'h10 | (r << CTRL_RATE_LO));
            bus(0, ADDR_CTRL, 0);
            chk("ctrl_rate", 32'h10 | (r << CTRL_RATE_LO), rd & 32'h1f);
        end
        // both stages off: bits pass straight through
        bus(1, ADDR_CTRL, 32'h10);
        frame(40);
        for (int k = 0; k < 40; k++) chk("plain_bit", sent_q[k], got_q[k]);
        // scrambler alone: self-synchronising descramble restores the data
        bus(1, ADDR_CTRL, 32'h12);
        frame(64);
        for (int k = 20; k < 64; k++) begin
            chk("descrambled", sent_q[k], got_q[k] ^ got_q[k-3] ^ got_q[k-20]);
        end
        chk("scram_active", 1, 32'(diffs != 0));
        // qpsk: the quadrature lane carries parity, so it must differ from in-phase
        qd = 0;
        for (int k = 0; k < 64; k++) qd += int'(quad_q[k] !== got_q[k]);
        chk("qpsk_split", 1, 32'(qd != 0));
        // differential encoder alone changes the stream
        bus(1, ADDR_CTRL, 32'h11);
        frame(32);
        chk("diff_active", 1, 32'(diffs != 0));
        // each lane of a pair is differenced against the same lane two bits back
        for (int k = 2; k < 32; k++) begin
            chk("diff_model", sent_q[k], got_q[k] ^ got_q[k-2]);
        end
        // bpsk, stages off, ramp taps 1..8: one unsplit lane into both filters
        bus(1, ADDR_COEF_BASE, 32'h0403_0201);
        bus(1, ADDR_COEF_BASE + 8'h04, 32'h0807_0605);
        bus(1, ADDR_CTRL, 32'h00);
        frame(24);
        exp_s = 0;
        for (int t = 0; t < FIR_TAPS; t++) exp_s += sent_q[23-t] ? t + 1 : -(t + 1);
        for (int k = 0; k < 24; k++) chk("bpsk_q", sent_q[k], quad_q[k]);
        chk("fir_i", 32'(FIR_OUT_W'(exp_s)), 32'(i_sample));
        chk("fir_q", 32'(FIR_OUT_W'(exp_s)), 32'(q_sample));
        // input clock loss: cleared right after traffic, set after the timeout
        bus(1, ADDR_STATUS, 32'h4);
        bus(0, ADDR_STATUS, 0);
        chk("clk_ok", 0, rd & 32'h4);
        repeat (LOSS + 50) @(posedge clk);
        bus(0, ADDR_STATUS, 0);
        chk("clk_lost", 32'h4, rd & 32'h4);
        // synthesizer fault raises the masked-in interrupt
        bus(1, ADDR_MASK, 32'h1);
        synth_unlock <= 1'b1;
        repeat (8) @(posedge clk);
        bus(0, ADDR_STATUS, 0);
        chk("synth_flag", 1, rd & 32'h1);
        synth_unlock <= 1'b0;
        @(negedge clk);
        chk("irq_on", 1, 32'(irq));
        repeat (8) @(posedge clk);
        bus(1, ADDR_STATUS, 32'h1);
        bus(0, ADDR_STATUS, 0);
        chk("synth_clear", 0, rd & 32'h1);
        chk("irq_off", 0, 32'(irq));
        // level fault held while masked out keeps the interrupt quiet
        bus(1, ADDR_MASK, 32'h0);
        agc_fault <= 1'b1;
        repeat (8) @(posedge clk);
        bus(0, ADDR_STATUS, 0);
        chk("agc_flag", 32'h2, rd & 32'h2);
        chk("irq_masked", 0, 32'(irq));
        bus(1, ADDR_MASK, 32'h2);
        agc_fault <= 1'b0;
        @(negedge clk);
        chk("irq_unmask", 1, 32'(irq));
        // data-rate clock follows the programmed divider
        bus(1, ADDR_RATE_DIV, 32'h3);
        rate_period();
        rate_period();
        chk("rate_half", 4, cyc);
        report_and_stop();
    end
endmodule : tb_tx_fec_scramble_datapath
